// ### design/bpfr_defines.svh
`ifndef BPFR_DEFINES_SVH
`define BPFR_DEFINES_SVH
// ==========================================
// register offsets
`define BPFR_OFS_PWM      8'h12
`define BPFR_OFS_BOOST    8'h13
`define BPFR_OFS_AFHI     8'h15
`define BPFR_OFS_AFLO     8'h16
`define BPFR_OFS_CEIL     8'h17
`define BPFR_OFS_BRLO     8'h18
`define BPFR_OFS_BRHI     8'h19
`define BPFR_OFS_FCTL     8'h1e
`define BPFR_OFS_FREP     8'h1f
// ==========================================
// reset values
`define BPFR_RST_PWM      8'h73
`define BPFR_RST_BOOST    8'h6f
`define BPFR_RST_AFHI     8'h00
`define BPFR_RST_AFLO     8'h00
`define BPFR_RST_CEIL     8'h00
`define BPFR_RST_BRLO     3'h7
`define BPFR_RST_BRHI     8'hff
`define BPFR_RST_FCTL     4'h7
// ==========================================
// writable masks and field positions
`define BPFR_MSK_BOOST    8'h7f
`define BPFR_BIT_SHORTEN  3
`define BPFR_BIT_THERM    2
`define BPFR_BIT_OVERCUR  1
`define BPFR_BIT_OVERVOLT 0
`define BPFR_BIT_OPEN     4
`define BPFR_BIT_SHORT    3
`define BPFR_HYST_BAD     3'h7
// ==========================================
// pulse filter times in ns, at 20 ns clock
`define BPFR_CLK_NS       20
`define BPFR_FILT1_NS     100
`define BPFR_FILT2_NS     150
`define BPFR_FILT3_NS     200
`endif

// ### design/bpfr_pkg.sv
package bpfr_pkg;
   typedef enum logic [1:0] {
      BPFR_FREQ_250K = 2'h0,
      BPFR_FREQ_500K = 2'h1,
      BPFR_FREQ_1M   = 2'h2
   } bpfr_freq_e;
   typedef enum logic [2:0] {
      BPFR_RUN  = 3'h1,
      BPFR_SHUT = 3'h2,
      BPFR_WAIT = 3'h4
   } bpfr_state_e;
endpackage

// ### design/bpfr_pwm_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpfr_defines.svh"
module bpfr_pwm_filter
   import bpfr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // control
   input  wire logic [1:0] filt_sel,
   input  wire logic       pol_high,
   // pwm
   input  wire logic       pwm_pin,
   output logic            pwm_clean
);
   localparam logic [3:0] T1 = 4'((`BPFR_FILT1_NS + `BPFR_CLK_NS - 1) / `BPFR_CLK_NS);
   localparam logic [3:0] T2 = 4'((`BPFR_FILT2_NS + `BPFR_CLK_NS - 1) / `BPFR_CLK_NS);
   localparam logic [3:0] T3 = 4'((`BPFR_FILT3_NS + `BPFR_CLK_NS - 1) / `BPFR_CLK_NS);
   logic       s1_reg;
   logic       s2_reg;
   logic       out_reg;
   logic [3:0] cnt_reg;
   wire        lvl = pol_high ? s2_reg : ~s2_reg;
   // ==========================================
   // filter width select
   wire [3:0]  need = (filt_sel == 2'h1) ? T1 : (filt_sel == 2'h2) ? T2 : T3;
   wire        nofilt = (filt_sel == 2'h0);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         out_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end else begin
         s1_reg <= pwm_pin;
         s2_reg <= s1_reg;
         if (nofilt || lvl == out_reg) begin
            cnt_reg <= 4'h0;
            if (nofilt) out_reg <= lvl;
         end else if (cnt_reg + 4'h1 >= need) begin
            cnt_reg <= 4'h0;
            out_reg <= lvl;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
   assign pwm_clean = out_reg;
endmodule // bpfr_pwm_filter
`default_nettype wire

// ### design/bpfr_regs.sv
// Notes on behaviour
// - sample rate field 00 slow, 01 mid default, 1x fast; polarity bit.
// - hysteresis 0..6 lsb, code 111 invalid, default 4.
// - pulse filter none, 100, 150, 200 ns; default 200 ns.
// - boost frequency bit and -12% shift bit, both default 1.
// - overvoltage bits 3:2 and current limit bits 1:0, default 11.
// - high threshold vs brightness msbs picks 500k or 1m.
// - low threshold vs brightness msbs picks 250k or 500k.
// - ceiling input high forces brightness msbs to ceiling register.
// - brightness lsbs in bits 2:0, default 111, rest read zero.
// - brightness msbs full register, default all ones.
// - short detection runs only when control bit 3 set.
// - enabled fault flag with disable bit 0 forces shutdown.
// - disable bits reset to one, faults only reported.
// - fault flags read only: open, short, thermal, current, voltage.
// - reserved bits and unmapped addresses read zero.
// - after fault shutdown, re-enable refused until flags read.
// - device enable rising restores pwm config reset value.
`timescale 1ns/1ps
`default_nettype none
`include "bpfr_defines.svh"
module bpfr_regs
   import bpfr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // register port from serial engine
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // device enable
   input  wire logic        dev_enable,
   output logic             dev_active,
   // link clock domain pwm pin
   input  wire logic        pwm_clk,
   input  wire logic        pwm_nrst,
   input  wire logic        pwm_pin,
   output logic             pwm_level,
   // brightness
   input  wire logic        brightness_ceiling_input,
   output logic      [10:0] brightness_code,
   // config outputs
   output logic      [1:0]  sample_rate,
   output logic      [2:0]  hysteresis_lsb,
   output logic             boost_1mhz,
   output logic             boost_no_shift,
   output logic             inductor_22uh,
   output logic      [1:0]  overvoltage_sel,
   output logic      [1:0]  ocl_sel,
   output bpfr_freq_e       auto_freq,
   output logic             short_detect_en,
   // fault events
   input  wire logic        open_evt,
   input  wire logic        short_evt,
   input  wire logic        thermal_shutdown,
   input  wire logic        overcurrent_limit,
   input  wire logic        overvoltage_limit
);
   // ==========================================
   // registers
   logic [7:0]  pwm_reg;
   logic [7:0]  boost_reg;
   logic [7:0]  afhi_reg;
   logic [7:0]  aflo_reg;
   logic [7:0]  ceil_reg;
   logic [2:0]  brlo_reg;
   logic [7:0]  brhi_reg;
   logic [3:0]  fctl_reg;
   logic [4:0]  flag_reg;
   logic [7:0]  rdata_reg;
   logic        en_d_reg;
   logic        ce1_reg;
   logic        ce2_reg;
   logic        pwm_sync1_reg;
   logic        pwm_sync2_reg;
   logic [2:0]  hyst_reg;
   bpfr_state_e state_reg;
   bpfr_state_e state_next;
   // ==========================================
   // decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction
   wire w_pwm   = reg_wr && hit(reg_addr, `BPFR_OFS_PWM);
   wire w_boost = reg_wr && hit(reg_addr, `BPFR_OFS_BOOST);
   wire w_afhi  = reg_wr && hit(reg_addr, `BPFR_OFS_AFHI);
   wire w_aflo  = reg_wr && hit(reg_addr, `BPFR_OFS_AFLO);
   wire w_ceil  = reg_wr && hit(reg_addr, `BPFR_OFS_CEIL);
   wire w_brlo  = reg_wr && hit(reg_addr, `BPFR_OFS_BRLO);
   wire w_brhi  = reg_wr && hit(reg_addr, `BPFR_OFS_BRHI);
   wire w_fctl  = reg_wr && hit(reg_addr, `BPFR_OFS_FCTL);
   wire r_frep  = reg_rd && hit(reg_addr, `BPFR_OFS_FREP);
   wire en_rise = dev_enable && !en_d_reg;
   // ==========================================
   // fault sources
   // short gated by enable
   wire [4:0] evt = {open_evt, short_evt && fctl_reg[`BPFR_BIT_SHORTEN],
                     thermal_shutdown, overcurrent_limit, overvoltage_limit};
   wire [2:0] shut_en = ~fctl_reg[2:0];
   wire       shut_req = |(flag_reg[2:0] & shut_en);
   // ==========================================
   // read mux
   // reserved and unmapped zero
   wire [7:0] rd_mux =
      hit(reg_addr, `BPFR_OFS_PWM)   ? pwm_reg :
      hit(reg_addr, `BPFR_OFS_BOOST) ? boost_reg :
      hit(reg_addr, `BPFR_OFS_AFHI)  ? afhi_reg :
      hit(reg_addr, `BPFR_OFS_AFLO)  ? aflo_reg :
      hit(reg_addr, `BPFR_OFS_CEIL)  ? ceil_reg :
      hit(reg_addr, `BPFR_OFS_BRLO)  ? {5'h00, brlo_reg} :
      hit(reg_addr, `BPFR_OFS_BRHI)  ? brhi_reg :
      hit(reg_addr, `BPFR_OFS_FCTL)  ? {4'h0, fctl_reg} :
      hit(reg_addr, `BPFR_OFS_FREP)  ? {3'h0, flag_reg} : 8'h00;
   // ==========================================
   // config registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwm_reg   <= `BPFR_RST_PWM;
         boost_reg <= `BPFR_RST_BOOST;
         afhi_reg  <= `BPFR_RST_AFHI;
         aflo_reg  <= `BPFR_RST_AFLO;
         ceil_reg  <= `BPFR_RST_CEIL;
         brlo_reg  <= `BPFR_RST_BRLO;
         brhi_reg  <= `BPFR_RST_BRHI;
         fctl_reg  <= `BPFR_RST_FCTL;
         en_d_reg  <= 1'b1;
      end else begin
         en_d_reg <= dev_enable;
         if (en_rise) pwm_reg <= `BPFR_RST_PWM;
         else if (w_pwm) pwm_reg <= reg_wdata;
         if (w_boost) boost_reg <= reg_wdata & `BPFR_MSK_BOOST;
         if (w_afhi) afhi_reg <= reg_wdata;
         if (w_aflo) aflo_reg <= reg_wdata;
         if (w_ceil) ceil_reg <= reg_wdata;
         if (w_brlo) brlo_reg <= reg_wdata[2:0];
         if (w_brhi) brhi_reg <= reg_wdata;
         if (w_fctl) fctl_reg <= reg_wdata[3:0];
      end
   end
   // ==========================================
   // fault flags, set wins over read clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flag_reg  <= 5'h00;
         rdata_reg <= 8'h00;
      end else begin
         flag_reg <= (r_frep ? 5'h00 : flag_reg) | evt;
         if (reg_rd) rdata_reg <= rd_mux;
      end
   end
   assign reg_rdata = rdata_reg;
   // ==========================================
   // shutdown state machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BPFR_RUN:  if (shut_req) state_next = BPFR_SHUT;
         BPFR_SHUT: if (r_frep) state_next = BPFR_WAIT;
         BPFR_WAIT: if (!dev_enable) state_next = BPFR_RUN;
         default:   state_next = BPFR_SHUT;
      endcase
   end
   always_ff @(posedge clk) begin
      if (!nrst) state_reg <= BPFR_RUN;
      else state_reg <= state_next;
   end
   assign dev_active = dev_enable && (state_reg == BPFR_RUN) && !shut_req;
   // ==========================================
   // brightness and auto frequency
   logic brightness_ceiling_input_s;
   wire [7:0] msb_eff = brightness_ceiling_input_s ? ceil_reg : brhi_reg;
   assign brightness_code = {msb_eff, brlo_reg};
   wire above_hi = msb_eff > afhi_reg;
   wire above_lo = msb_eff > aflo_reg;
   assign auto_freq = above_hi ? BPFR_FREQ_1M : above_lo ? BPFR_FREQ_500K : BPFR_FREQ_250K;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ce1_reg <= 1'b0;
         ce2_reg <= 1'b0;
      end else begin
         ce1_reg <= brightness_ceiling_input;
         ce2_reg <= ce1_reg;
      end
   end
   assign brightness_ceiling_input_s = ce2_reg;
   // ==========================================
   // config fields
   // sample rate and hysteresis
   assign sample_rate = pwm_reg[7] ? 2'h2 : {1'b0, pwm_reg[6]};
   always_ff @(posedge clk) begin
      if (!nrst) hyst_reg <= 3'h4;
      else if (pwm_reg[4:2] != `BPFR_HYST_BAD) hyst_reg <= pwm_reg[4:2];
   end
   assign hysteresis_lsb = hyst_reg;
   assign boost_no_shift = boost_reg[6];
   assign boost_1mhz     = boost_reg[5];
   assign inductor_22uh  = boost_reg[4];
   assign overvoltage_sel = boost_reg[3:2];
   assign ocl_sel = boost_reg[1:0];
   assign short_detect_en = fctl_reg[`BPFR_BIT_SHORTEN];
   // ==========================================
   // pwm filter in link domain, level crossed back
   logic pol_s1_reg;
   logic pol_s2_reg;
   logic [1:0] fs1_reg;
   logic [1:0] fs2_reg;
   logic pwm_fast;
   always_ff @(posedge pwm_clk) begin
      if (!pwm_nrst) begin
         pol_s1_reg <= 1'b1;
         pol_s2_reg <= 1'b1;
         fs1_reg    <= 2'h3;
         fs2_reg    <= 2'h3;
      end else begin
         pol_s1_reg <= pwm_reg[5];
         pol_s2_reg <= pol_s1_reg;
         fs1_reg    <= pwm_reg[1:0];
         fs2_reg    <= fs1_reg;
      end
   end
   bpfr_pwm_filter u_filt (
      .clk       (pwm_clk),
      .nrst      (pwm_nrst),
      .filt_sel  (fs2_reg),
      .pol_high  (pol_s2_reg),
      .pwm_pin   (pwm_pin),
      .pwm_clean (pwm_fast)
   );
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwm_sync1_reg <= 1'b0;
         pwm_sync2_reg <= 1'b0;
      end else begin
         pwm_sync1_reg <= pwm_fast;
         pwm_sync2_reg <= pwm_sync1_reg;
      end
   end
   assign pwm_level = pwm_sync2_reg;
endmodule // bpfr_regs
`default_nettype wire

// ### sim/bpfr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module bpfr_regs_props
   import bpfr_pkg::*;
(
   // watched ports
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        dev_enable,
   input wire logic        dev_active,
   input wire logic [10:0] brightness_code,
   input wire logic [1:0]  sample_rate,
   input wire logic [2:0]  hysteresis_lsb,
   input wire logic        boost_1mhz,
   input wire logic        boost_no_shift,
   input wire logic [1:0]  overvoltage_sel,
   input wire logic [1:0]  ocl_sel,
   input wire logic        short_detect_en
);
   // ==========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic mapped = reg_addr inside {8'h12, 8'h13, [8'h15:8'h19], 8'h1e, 8'h1f};
   wire logic wr_pwm = reg_wr && reg_addr == 8'h12;
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_brlo_reserved: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata[7:3] == 5'h00)
      else $error("brightness low reserved bits not zero");
   a_rate_write: assert property (wr_pwm && !$rose(dev_enable) |=>
      sample_rate == ($past(reg_wdata[7]) ? 2'h2 : {1'b0, $past(reg_wdata[6])}))
      else $error("sample rate not taken");
   a_hyst_write: assert property (wr_pwm && reg_wdata[4:2] != 3'h7 && !$rose(dev_enable) |=>
      ##1 hysteresis_lsb == $past(reg_wdata[4:2], 2)) else $error("hysteresis not taken");
   a_hyst_keep: assert property (wr_pwm && reg_wdata[4:2] == 3'h7 && !$rose(dev_enable) |=>
      ##1 $stable(hysteresis_lsb)) else $error("invalid hysteresis taken");
   a_boost_write: assert property (reg_wr && reg_addr == 8'h13 |=>
      {boost_no_shift, boost_1mhz, overvoltage_sel, ocl_sel} ==
      {$past(reg_wdata[6:5]), $past(reg_wdata[3:0])})
      else $error("boost fields not taken");
   a_short_write: assert property (reg_wr && reg_addr == 8'h1e |=>
      short_detect_en == $past(reg_wdata[3])) else $error("short enable not taken");
   a_enable_restore: assert property ($rose(dev_enable) |=>
      sample_rate == 2'h1 ##1 hysteresis_lsb == 3'h4) else $error("enable did not restore");
   a_active_enable: assert property (!dev_enable |-> !dev_active)
      else $error("active while disabled");
   a_brlo_code: assert property (reg_wr && reg_addr == 8'h18 |=>
      brightness_code[2:0] == $past(reg_wdata[2:0])) else $error("brightness low not applied");
endmodule // bpfr_regs_props
`default_nettype wire

// ### sim/bpfr_host.sv
`timescale 1ns/1ps
`default_nettype none
module bpfr_host (
   // register port
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // ==========================================
   // host cycles
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
endmodule // bpfr_host
`default_nettype wire

// ### sim/backlight_pwm_boost_fault_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module backlight_pwm_boost_fault_regs_bench
   import bpfr_pkg::*;
();
   logic        clk = 1'b0, pwm_clk = 1'b0, nrst = 1'b0, pwm_nrst = 1'b0;
   logic        dev_enable = 1'b1, pwm_pin = 1'b0, ceil_in = 1'b0;
   logic [4:0]  evt = 5'h00;
   logic        reg_wr, reg_rd, dev_active, pwm_level, b1m, bns, ind, sde;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, r;
   logic [10:0] bcode;
   logic [1:0]  srate, ovs, ocl;
   logic [2:0]  hyst;
   logic [2:0]  hy = 3'h4;
   bpfr_freq_e  af;
   logic [7:0]  sh [0:31];
   logic [7:0]  adr [0:8] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1e, 8'h1f};
   int          fails = 0, comparisons = 0, cyc = 0;
   bpfr_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   bpfr_regs i_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .dev_enable(dev_enable), .dev_active(dev_active), .pwm_clk(pwm_clk),
      .pwm_nrst(pwm_nrst), .pwm_pin(pwm_pin), .pwm_level(pwm_level),
      .brightness_ceiling_input(ceil_in), .brightness_code(bcode), .sample_rate(srate),
      .hysteresis_lsb(hyst), .boost_1mhz(b1m), .boost_no_shift(bns), .inductor_22uh(ind),
      .overvoltage_sel(ovs), .ocl_sel(ocl), .auto_freq(af), .short_detect_en(sde),
      .open_evt(evt[4]), .short_evt(evt[3]), .thermal_shutdown(evt[2]),
      .overcurrent_limit(evt[1]), .overvoltage_limit(evt[0]));
   // ==========================================
   // helpers
   function automatic logic [7:0] msk(input logic [7:0] x);
      case (x)
         8'h13: return 8'h7f;
         8'h18: return 8'h07;
         8'h1e: return 8'h0f;
         8'h1f: return 8'h00;
         default: return 8'hff;
      endcase
   endfunction
   function automatic bpfr_freq_e ef(input logic [7:0] m, input logic [7:0] hi, lo);
      if (m > hi) return BPFR_FREQ_1M;
      if (m > lo) return BPFR_FREQ_500K;
      return BPFR_FREQ_250K;
   endfunction
   task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic w(input logic [7:0] x, input logic [7:0] v);
      i_host.wr(x, v);
      if (x == 8'h12 && v[4:2] != 3'h7) hy = v[4:2];
      sh[x[4:0]] = v & msk(x);
   endtask
   task automatic rc(input logic [7:0] x);
      i_host.rd(x, r);
      chk("rdata", 11'(r), 11'(x < 8'h20 ? sh[x[4:0]] : 8'h00));
   endtask
   task automatic cfg();
      @(posedge clk);
      #1;
      chk("rate", 11'(srate), 11'(sh[5'h12][7] ? 2'h2 : {1'b0, sh[5'h12][6]}));
      chk("hyst", 11'(hyst), 11'(hy));
      chk("boost", 11'({bns, b1m, ind, ovs, ocl}), 11'(sh[5'h13][6:0]));
      chk("code", bcode, {sh[5'h19], sh[5'h18][2:0]});
      chk("short_en", 11'(sde), 11'(sh[5'h1e][3]));
      chk("afreq", 11'(af), 11'(ef(sh[5'h19], sh[5'h15], sh[5'h16])));
   endtask
   task automatic report_and_stop();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // clocks, timeout, sequence
   initial forever #10 clk = ~clk;
   initial begin
      #3;
      forever #7.5 pwm_clk = ~pwm_clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      r = 8'($urandom(27));
      for (int i = 0; i < 32; i++) sh[i] = 8'h00;
      sh[5'h12] = 8'h73;
      sh[5'h13] = 8'h6f;
      sh[5'h18] = 8'h07;
      sh[5'h19] = 8'hff;
      sh[5'h1e] = 8'h07;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge pwm_clk) pwm_nrst <= 1'b1;
      for (int i = 8'h10; i < 8'h22; i++) rc(8'(i));
      cfg();
      w(8'h12, 8'h9f);
      rc(8'h12);
      repeat (40) begin
         w(adr[$urandom % 9], 8'($urandom));
         cfg();
         rc(adr[$urandom % 9]);
      end
      @(posedge clk) ceil_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk("ceiling", 11'(bcode[10:3]), 11'(sh[5'h17]));
      w(8'h1e, 8'h0f);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) evt <= 5'h01 << i;
         @(posedge clk) evt <= 5'h00;
         i_host.rd(8'h1f, r);
         chk("flag", 11'(r), 11'(8'h01 << i));
         chk("report_only", 11'(dev_active), 11'h001);
         rc(8'h1f);
      end
      for (int i = 0; i < 3; i++) begin
         w(8'h12, 8'h00);
         w(8'h1e, 8'h08);
         @(posedge clk) evt <= 5'h01 << i;
         @(posedge clk) evt <= 5'h00;
         #1 chk("shutdown", 11'(dev_active), 11'h000);
         @(posedge clk) dev_enable <= 1'b0;
         @(posedge clk) dev_enable <= 1'b1;
         @(posedge clk) #1 chk("refused", 11'(dev_active), 11'h000);
         i_host.rd(8'h1f, r);
         @(posedge clk) dev_enable <= 1'b0;
         @(posedge clk) dev_enable <= 1'b1;
         @(posedge clk) #1 chk("enabled", 11'(dev_active), 11'h001);
         sh[5'h12] = 8'h73;
         hy = 3'h4;
         rc(8'h12);
      end
      @(posedge pwm_clk) pwm_pin <= 1'b1;
      @(posedge pwm_clk) pwm_pin <= 1'b0;
      repeat (30) @(posedge clk);
      chk("glitch", 11'(pwm_level), 11'h000);
      @(posedge pwm_clk) pwm_pin <= 1'b1;
      repeat (30) @(posedge clk);
      chk("level", 11'(pwm_level), 11'h001);
      w(8'h12, 8'h53);
      repeat (30) @(posedge clk);
      chk("polarity", 11'(pwm_level), 11'h000);
      report_and_stop();
   end
endmodule // backlight_pwm_boost_fault_regs_bench
bind bpfr_regs bpfr_regs_props i_props (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .dev_enable(dev_enable), .dev_active(dev_active), .brightness_code(brightness_code),
   .sample_rate(sample_rate), .hysteresis_lsb(hysteresis_lsb), .boost_1mhz(boost_1mhz),
   .boost_no_shift(boost_no_shift), .overvoltage_sel(overvoltage_sel), .ocl_sel(ocl_sel),
   .short_detect_en(short_detect_en));
`default_nettype wire
